// File: hdl/period_timer_pkg.sv
// constants shared by the period timer
package period_timer_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] FLAG_IDX = 8'h0C;
    localparam logic [7:0] COUNT_IDX = 8'h11;
    localparam logic [7:0] CTRL_IDX = 8'h12;
    localparam logic [7:0] MASK_IDX = 8'h8C;
    localparam logic [7:0] LIMIT_IDX = 8'h92;
    // control field positions
    localparam int PRE_LSB = 0;
    localparam int RUN_BIT = 2;
    localparam int POST_LSB = 3;
    // match flag position in flag and mask registers
    localparam int MATCH_BIT = 1;
    // implemented bits of the control register
    localparam logic [7:0] CTRL_MASK = 8'h7F;
    // values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] LIMIT_RST = 8'hFF;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    // terminal count of the four-clock instruction clock divider
    localparam logic [1:0] INST_LAST = 2'h3;
    // prescaler terminal counts for ratios 1, 4 and 16
    localparam logic [3:0] PRE_LAST_1 = 4'h0;
    localparam logic [3:0] PRE_LAST_4 = 4'h3;
    localparam logic [3:0] PRE_LAST_16 = 4'hF;
endpackage

// File: hdl/period_timer.sv
// 8-bit period timer with prescaler, postscaler and apb registers
//
// Our own choice: the APB register port.
module period_timer #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // pwm time base
    output logic [7:0] timeBaseCount,
    output logic timeBaseMatch
);
    // elaboration check on address width
    if (ADDR_W < 11) begin : g_addr_chk
        $error("ADDR_W must be at least 11");
    end

    logic [1:0] instCnt_reg;
    logic [3:0] preCnt_reg;
    logic [3:0] postCnt_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] count_reg;
    logic [7:0] limit_reg;
    logic [7:0] flag_reg;
    logic [7:0] mask_reg;
    logic [31:0] prdata_reg;
    logic match_reg;
    logic [7:0] count_next;
    logic [3:0] preCnt_next;
    logic [3:0] postCnt_next;
    logic [7:0] flag_next;

    // bus decode
    wire setupPh = psel && !penable;
    wire accessPh = psel && penable;
    wire [7:0] regIdx = paddr[9:2];
    wire addrOk = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    wire hitFlag = addrOk && regIdx == period_timer_pkg::FLAG_IDX;
    wire hitCount = addrOk && regIdx == period_timer_pkg::COUNT_IDX;
    wire hitCtrl = addrOk && regIdx == period_timer_pkg::CTRL_IDX;
    wire hitMask = addrOk && regIdx == period_timer_pkg::MASK_IDX;
    wire hitLimit = addrOk && regIdx == period_timer_pkg::LIMIT_IDX;
    wire mapped = hitFlag || hitCount || hitCtrl || hitMask || hitLimit;
    wire wrEn = accessPh && pwrite && mapped;
    wire wrFlag = wrEn && hitFlag;
    wire wrCount = wrEn && hitCount;
    wire wrCtrl = wrEn && hitCtrl;
    wire wrMask = wrEn && hitMask;
    wire wrLimit = wrEn && hitLimit;
    wire [7:0] wByte = pwdata[7:0];

    // read mux; value taken in setup, presented in access
    wire [7:0] rdByte = hitFlag ? flag_reg :
                        hitCount ? count_reg :
                        hitCtrl ? ctrl_reg :
                        hitMask ? mask_reg :
                        hitLimit ? limit_reg : 8'h00;

    // control fields
    wire runOn = ctrl_reg[period_timer_pkg::RUN_BIT];
    wire [1:0] preSel = ctrl_reg[period_timer_pkg::PRE_LSB +: 2];
    wire [3:0] postSel = ctrl_reg[period_timer_pkg::POST_LSB +: 4];

    // instruction clock tick, oscillator divided by four
    wire instTick = instCnt_reg == period_timer_pkg::INST_LAST;

    // prescaler terminal count
    wire [3:0] preLast = preSel[1] ? period_timer_pkg::PRE_LAST_16 :
                         preSel[0] ? period_timer_pkg::PRE_LAST_4 :
                                     period_timer_pkg::PRE_LAST_1;

    // scaler clear on counter or control write
    wire scalerClr = wrCount || wrCtrl;

    // counter increments on prescaler tick while running
    wire incTick = runOn && instTick && (preCnt_reg == preLast);
    wire atLimit = count_reg == limit_reg;
    wire matchEv = incTick && atLimit && !wrCount;
    wire postTick = matchEv && (postCnt_reg == postSel) && !wrCtrl;

    // prescaler next value
    always_comb begin
        preCnt_next = preCnt_reg;
        if (scalerClr) begin
            preCnt_next = 4'h0;
        end else if (runOn && instTick) begin
            preCnt_next = (preCnt_reg == preLast) ? 4'h0 : preCnt_reg + 4'h1;
        end
    end

    // postscaler next value
    always_comb begin
        postCnt_next = postCnt_reg;
        if (scalerClr) begin
            postCnt_next = 4'h0;
        end else if (matchEv) begin
            postCnt_next = (postCnt_reg == postSel) ? 4'h0 : postCnt_reg + 4'h1;
        end
    end

    // counter next value; software write wins over increment
    always_comb begin
        count_next = count_reg;
        if (wrCount) begin
            count_next = wByte;
        end else if (incTick) begin
            count_next = atLimit ? 8'h00 : count_reg + 8'h01;
        end
    end

    // sticky flag: write one clears, a new set wins
    always_comb begin
        flag_next = flag_reg;
        if (wrFlag) begin
            flag_next = flag_reg & ~wByte;
        end
        if (postTick) begin
            flag_next[period_timer_pkg::MATCH_BIT] = 1'b1;
        end
        flag_next = flag_next & (8'h01 << period_timer_pkg::MATCH_BIT);
    end

    // scalers and instruction divider
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            instCnt_reg <= 2'h0;
            preCnt_reg <= 4'h0;
            postCnt_reg <= 4'h0;
        end else begin
            instCnt_reg <= instCnt_reg + 2'h1;
            preCnt_reg <= preCnt_next;
            postCnt_reg <= postCnt_next;
        end
    end

    // counter and limit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_reg <= period_timer_pkg::COUNT_RST;
            limit_reg <= period_timer_pkg::LIMIT_RST;
        end else begin
            count_reg <= count_next;
            if (wrLimit) begin
                limit_reg <= wByte;
            end
        end
    end

    // control, mask and flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg <= period_timer_pkg::CTRL_RST;
            mask_reg <= period_timer_pkg::MASK_RST;
            flag_reg <= period_timer_pkg::FLAG_RST;
        end else begin
            if (wrCtrl) begin
                ctrl_reg <= wByte & period_timer_pkg::CTRL_MASK;
            end
            if (wrMask) begin
                mask_reg <= wByte & (8'h01 << period_timer_pkg::MATCH_BIT);
            end
            flag_reg <= flag_next;
        end
    end

    // read data and time base match pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_reg <= 32'h0000_0000;
            match_reg <= 1'b0;
        end else begin
            if (setupPh) begin
                prdata_reg <= {24'h00_0000, rdByte};
            end
            match_reg <= matchEv;
        end
    end

    // outputs
    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = accessPh && !mapped;
    assign irq = |(flag_reg & mask_reg);
    assign timeBaseCount = count_reg;
    assign timeBaseMatch = match_reg;

    // checks
    property p_ctr_reset;
        @(posedge clk) sys_rst |=> count_reg == 8'h00;
    endproperty
    a_ctr_reset: assert property (p_ctr_reset) else $error("counter not zero after reset");

    property p_lim_reset;
        @(posedge clk) sys_rst |=> limit_reg == 8'hFF;
    endproperty
    a_lim_reset: assert property (p_lim_reset) else $error("limit not FF after reset");

    property p_scaler_clr;
        @(posedge clk) disable iff (sys_rst)
        (wrCount || wrCtrl) |=> preCnt_reg == 4'h0 && postCnt_reg == 4'h0;
    endproperty
    a_scaler_clr: assert property (p_scaler_clr) else $error("scalers not cleared");

    property p_ctrl_keeps;
        @(posedge clk) disable iff (sys_rst)
        wrCtrl && !incTick |=> count_reg == $past(count_reg);
    endproperty
    a_ctrl_keeps: assert property (p_ctrl_keeps) else $error("control write moved counter");

    property p_hold_stop;
        @(posedge clk) disable iff (sys_rst)
        !runOn && !wrCount |=> $stable(count_reg);
    endproperty
    a_hold_stop: assert property (p_hold_stop) else $error("counter moved while stopped");

    property p_wrap;
        @(posedge clk) disable iff (sys_rst)
        incTick && atLimit && !wrCount |=> count_reg == 8'h00 && timeBaseMatch;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap at limit");

    property p_pre1;
        @(posedge clk) disable iff (sys_rst)
        runOn && preSel == 2'h0 |-> incTick == instTick;
    endproperty
    a_pre1: assert property (p_pre1) else $error("prescale 1 wrong");

    property p_inst;
        @(posedge clk) disable iff (sys_rst)
        incTick |-> ##1 !incTick ##1 !incTick ##1 !incTick;
    endproperty
    a_inst: assert property (p_inst) else $error("increments closer than four clocks");

    property p_post;
        @(posedge clk) disable iff (sys_rst)
        postCnt_reg <= postSel;
    endproperty
    a_post: assert property (p_post) else $error("postscaler count beyond select");

    property p_flag_set;
        @(posedge clk) disable iff (sys_rst)
        matchEv && postSel == 4'h0 && !wrCtrl |=> flag_reg[1];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("match did not set flag");

    property p_flag_hold;
        @(posedge clk) disable iff (sys_rst)
        flag_reg[1] && !(wrFlag && wByte[1]) |=> flag_reg[1];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped by itself");

    property p_run_moves;
        @(posedge clk) disable iff (sys_rst)
        incTick && !atLimit && !wrCount |=> count_reg == $past(count_reg) + 8'h01;
    endproperty
    a_run_moves: assert property (p_run_moves) else $error("counter did not step");
endmodule

// File: test/period_timer_bench.sv
// self-checking bench for the period timer over apb
module period_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sysRst, psel, penable, pwrite, pready, pslverr, irq, timeBaseMatch, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v, c1;
    logic [7:0] timeBaseCount;
    int n_mismatch, tests_run, seed;
    period_timer dut (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .timeBaseCount(timeBaseCount),
        .timeBaseMatch(timeBaseMatch));
    // free running clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("tests %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] idx, input logic [1:0] off,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, off};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reset_vals;
        apb(1'b0, period_timer_pkg::COUNT_IDX, 2'h0, 32'h0);
        check(rd, {24'h0, period_timer_pkg::COUNT_RST});
        apb(1'b0, period_timer_pkg::LIMIT_IDX, 2'h0, 32'h0);
        check(rd, {24'h0, period_timer_pkg::LIMIT_RST});
        apb(1'b0, period_timer_pkg::CTRL_IDX, 2'h0, 32'h0);
        check(rd, {24'h0, period_timer_pkg::CTRL_RST});
        apb(1'b0, period_timer_pkg::FLAG_IDX, 2'h0, 32'h0);
        check(rd, {24'h0, period_timer_pkg::FLAG_RST});
        apb(1'b0, period_timer_pkg::MASK_IDX, 2'h0, 32'h0);
        check(rd, {24'h0, period_timer_pkg::MASK_RST});
        $display("test reset values done");
    endtask
    // run one period with given scalers, time the interrupt
    task automatic timed(input logic [1:0] pre, input logic [3:0] post, input logic [7:0] lim);
        int r, n, cyc, nm;
        logic over;
        r = (pre == 2'h0) ? 1 : ((pre == 2'h1) ? 4 : 16);
        n = (int'(lim) + 1) * (int'(post) + 1);
        cyc = 0;
        nm = 0;
        over = 1'b0;
        apb(1'b1, period_timer_pkg::CTRL_IDX, 2'h0, 32'h0);
        apb(1'b1, period_timer_pkg::FLAG_IDX, 2'h0, 32'h2);
        apb(1'b1, period_timer_pkg::MASK_IDX, 2'h0, 32'h2);
        apb(1'b1, period_timer_pkg::LIMIT_IDX, 2'h0, {24'h0, lim});
        apb(1'b1, period_timer_pkg::COUNT_IDX, 2'h0, 32'h0);
        apb(1'b1, period_timer_pkg::CTRL_IDX, 2'h0, {25'h0, post, 1'b1, pre});
        while (irq !== 1'b1 && cyc < 20000) begin
            @(posedge clk);
            cyc++;
            if (timeBaseCount > lim) over = 1'b1;
            if (timeBaseMatch === 1'b1) nm++;
        end
        check(32'(cyc >= 4 * r * n - 3 && cyc <= 4 * r * n), 32'h1);
        check(nm, int'(post) + 1);
        check({31'h0, over}, 32'h0);
        apb(1'b1, period_timer_pkg::CTRL_IDX, 2'h0, {25'h0, post, 1'b0, pre});
        apb(1'b0, period_timer_pkg::COUNT_IDX, 2'h0, 32'h0);
        c1 = rd;
        repeat (40) @(posedge clk);
        apb(1'b1, period_timer_pkg::CTRL_IDX, 2'h0, {25'h0, post, 1'b0, pre});
        apb(1'b0, period_timer_pkg::COUNT_IDX, 2'h0, 32'h0);
        check(rd, c1);
        apb(1'b0, period_timer_pkg::FLAG_IDX, 2'h0, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, period_timer_pkg::MASK_IDX, 2'h0, 32'h0);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, period_timer_pkg::MASK_IDX, 2'h0, 32'h2);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, period_timer_pkg::FLAG_IDX, 2'h0, 32'hFFFFFFFF);
        apb(1'b0, period_timer_pkg::FLAG_IDX, 2'h0, 32'h0);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test timed prescale %0d done", pre);
    endtask
    // main sequence
    initial begin
        seed = 10460;
        n_mismatch = 0;
        tests_run = 0;
        sysRst = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        reset_vals();
        v = $random(seed);
        apb(1'b1, period_timer_pkg::LIMIT_IDX, 2'h0, v);
        apb(1'b0, period_timer_pkg::LIMIT_IDX, 2'h0, 32'h0);
        check(rd, {24'h0, v[7:0]});
        apb(1'b1, period_timer_pkg::COUNT_IDX, 2'h0, ~v);
        apb(1'b0, period_timer_pkg::COUNT_IDX, 2'h0, 32'h0);
        check(rd, {24'h0, ~v[7:0]});
        apb(1'b1, period_timer_pkg::CTRL_IDX, 2'h0, 32'hFFFFFF80);
        apb(1'b0, period_timer_pkg::CTRL_IDX, 2'h0, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h01, 2'h0, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b0, period_timer_pkg::LIMIT_IDX, 2'h1, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            v = $random(seed);
            timed(2'(p), v[3:0], {6'h0, v[9:8]});
        end
        apb(1'b1, period_timer_pkg::CTRL_IDX, 2'h0, 32'h4);
        repeat (30) @(posedge clk);
        sysRst <= 1'b1;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        check({24'h0, timeBaseCount}, 32'h0);
        reset_vals();
        report_and_stop();
    end
    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
